// file: verilog/tpg_bank.sv
// Pattern generator bank of the sequencer controller card
// Behaviour
// - Drive a 64-bit backplane word from four 16-bit generators side by side.
// - Each generator is a pattern RAM read by its own address counter.
// - Each counter has a count length that software programs.
// - Counters can cascade to form a longer combined count.
// - Host preloads pattern RAM before a run; the run uses that content.
// - Optionally serialise a generator's output onto backplane lines.
// - 200 MHz clock, 10 MHz vector rate, 5 ns edge resolution.
// - Pattern words also feed the signature hardware.
// - Sequencer applies patterns and runs tests without the host.
// - Conditional jumps resolve at full vector speed without stopping delivery.
// - Host-loaded programming data is delivered by the generators.
// - Backplane outputs serve up to 18 pin channel cards.
// - Sequence can pause for other tests; releasing the pause pulses the analog trigger.
// - Single-step mode pauses at each step end; steps run at full speed.
`timescale 1ns/1ps
`include "tpg_consts.svh"
module tpg_bank
#(
	parameter int NGEN  = `TPG_NUM_GEN,
	parameter int DW    = `TPG_GEN_WIDTH,
	parameter int AW    = `TPG_ADDR_WIDTH,
	parameter int VDIV  = `TPG_VEC_DIV
)
(
	input  wire logic                            clk,
	input  wire logic                            nrst,
	input  wire logic                            ce,
	input  wire tpg_pkg::tpg_load_type           load,
	input  wire tpg_pkg::tpg_gen_cfg_type [3:0]  genCfg,
	input  wire tpg_pkg::tpg_ctrl_type           ctrl,
	input  wire logic                            jumpCond,
	output logic [NGEN*DW-1:0]                   patternWord,
	output logic [NGEN-1:0]                      serialLine,
	output logic                                 vectorStrobe,
	output logic                                 sigStrobe,
	output logic                                 analogTrigger,
	output logic                                 running,
	output logic                                 stepDone
);
	// Clock period and vector time; divider derived from them
	localparam int CLK_NS = `TPG_CLK_NS;
	localparam int VEC_NS = `TPG_NS_PER_US / `TPG_VEC_MHZ;
	localparam int VEC_CYC = VEC_NS / CLK_NS;

	tpg_pkg::tpg_state_type state_reg;
	tpg_pkg::tpg_state_type state_next;
	logic [`TPG_DIV_W-1:0] div_reg;
	logic                  tick;
	logic [AW-1:0]         addr_reg [NGEN];
	logic [NGEN-1:0]       wrap;
	logic [NGEN-1:0]       adv;
	logic [DW-1:0]         ramData [NGEN];
	logic [DW-1:0]         shift_reg [NGEN];
	logic [`TPG_SER_CNT_W-1:0] serCnt_reg;
	logic                  active;
	logic                  tick_d;

	// Counter reaches its last location
	function automatic logic atEnd(input logic [AW-1:0] a,
		input tpg_pkg::tpg_gen_cfg_type c);
		atEnd = (a == AW'(c.startAddr + c.length - `TPG_ADDR_ONE));
	endfunction

	assign active = (state_reg == tpg_pkg::TPG_RUN);
	assign tick = active && (div_reg == `TPG_DIV_W'(VEC_CYC - 1));

	// Vector rate divider
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			div_reg <= '0;
		else if (ce)
		begin
			if (!active || tick)
				div_reg <= '0;
			else
				div_reg <= div_reg + `TPG_DIV_W'(1);
		end
	end

	// Run control with pause and single step
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			tpg_pkg::TPG_IDLE:
				if (ctrl.start)
					state_next = tpg_pkg::TPG_RUN;
			tpg_pkg::TPG_RUN:
				if (ctrl.stop)
					state_next = tpg_pkg::TPG_IDLE;
				else if (ctrl.pause)
					state_next = tpg_pkg::TPG_PAUSED;
				else if (tick && ctrl.singleStep)
					state_next = tpg_pkg::TPG_STEPEND;
			tpg_pkg::TPG_PAUSED:
				if (ctrl.stop)
					state_next = tpg_pkg::TPG_IDLE;
				else if (!ctrl.pause)
					state_next = tpg_pkg::TPG_RUN;
			tpg_pkg::TPG_STEPEND:
				if (ctrl.stop)
					state_next = tpg_pkg::TPG_IDLE;
				else if (ctrl.stepGo || !ctrl.singleStep)
					state_next = tpg_pkg::TPG_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state_reg <= tpg_pkg::TPG_IDLE;
		else if (ce)
			state_reg <= state_next;
	end

	// Counter chain: cascaded counters advance on the previous one's wrap
	genvar g;
	generate
		for (g = 0; g < NGEN; g++)
		begin : gen_chan
			if (g == 0)
				assign adv[g] = tick;
			else
				assign adv[g] = genCfg[g].cascade ? (adv[g-1] && wrap[g-1]) : tick;
			assign wrap[g] = atEnd(addr_reg[g], genCfg[g]);

			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
					addr_reg[g] <= `TPG_ADDR_ZERO;
				else if (ce)
				begin
					if (state_reg == tpg_pkg::TPG_IDLE)
						addr_reg[g] <= genCfg[g].startAddr;
					else if (g == 0 && tick && ctrl.jumpEn && jumpCond)
						addr_reg[g] <= ctrl.jumpAddr;
					else if (adv[g])
						addr_reg[g] <= wrap[g] ? genCfg[g].startAddr
							: addr_reg[g] + AW'(1);
				end
			end

			tpg_pattern_ram #(.AW(AW), .DW(DW)) u_ram
			(
				.clk    (clk),
				.ce     (ce),
				.we     (load.we && (load.gen == 2'(g))),
				.wrAddr (load.addr),
				.wrData (load.data),
				.rdAddr (addr_reg[g]),
				.rdData (ramData[g])
			);

			// Shifter for serial mode, reloaded each vector
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					shift_reg[g]  <= `TPG_WORD_ZERO;
					serialLine[g] <= 1'b0;
				end
				else if (ce)
				begin
					if (tick_d)
						shift_reg[g] <= ramData[g];
					else
						shift_reg[g] <= {shift_reg[g][DW-2:0], 1'b0};
					serialLine[g] <= genCfg[g].serial ? shift_reg[g][DW-1] : 1'b0;
				end
			end

			// Parallel word slice, held at zero while serialised
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
					patternWord[g*DW +: DW] <= `TPG_WORD_ZERO;
				else if (ce && tick_d)
					patternWord[g*DW +: DW] <= genCfg[g].serial ? `TPG_WORD_ZERO
						: ramData[g];
			end
		end
	endgenerate

	// Serial bit counter, restarted on each vector
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			serCnt_reg <= '0;
		else if (ce)
			serCnt_reg <= tick_d ? '0 : (serCnt_reg == `TPG_SER_LAST ? serCnt_reg
				: serCnt_reg + `TPG_SER_CNT_W'(1));
	end

	// Delayed tick lines up with registered RAM data
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tick_d        <= 1'b0;
			vectorStrobe  <= 1'b0;
			sigStrobe     <= 1'b0;
			analogTrigger <= 1'b0;
			running       <= 1'b0;
			stepDone      <= 1'b0;
		end
		else if (ce)
		begin
			tick_d        <= tick;
			vectorStrobe  <= tick_d;
			sigStrobe     <= tick_d;
			analogTrigger <= (state_reg == tpg_pkg::TPG_PAUSED) && !ctrl.pause;
			running       <= (state_next == tpg_pkg::TPG_RUN);
			stepDone      <= (state_next == tpg_pkg::TPG_STEPEND);
		end
	end

	property p_tick_spacing;
		@(posedge clk) disable iff (!nrst)
		(ce && tick) |=> !tick;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("tick repeated");

	property p_wrap;
		@(posedge clk) disable iff (!nrst)
		(ce && adv[1] && wrap[1] && !(state_reg == tpg_pkg::TPG_IDLE))
			|=> (addr_reg[1] == genCfg[1].startAddr);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_cascade;
		@(posedge clk) disable iff (!nrst)
		(genCfg[1].cascade && tick && !wrap[0]) |-> !adv[1];
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascade advanced early");

	property p_strobe;
		@(posedge clk) disable iff (!nrst)
		(ce && tick) ##1 ce |=> vectorStrobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe missing");

	property p_step;
		@(posedge clk) disable iff (!nrst)
		(ce && state_reg == tpg_pkg::TPG_STEPEND && !ctrl.stepGo && ctrl.singleStep
			&& !ctrl.stop) |=> !tick;
	endproperty
	a_step: assert property (p_step) else $error("ran during step end");

	property p_pause;
		@(posedge clk) disable iff (!nrst)
		(state_reg == tpg_pkg::TPG_PAUSED) |-> !tick;
	endproperty
	a_pause: assert property (p_pause) else $error("ticked while paused");

	property p_serial_zero;
		@(posedge clk) disable iff (!nrst)
		(ce && tick_d && genCfg[0].serial) |=> (patternWord[DW-1:0] == '0);
	endproperty
	a_serial_zero: assert property (p_serial_zero) else $error("parallel not muted");

	property p_jump;
		@(posedge clk) disable iff (!nrst)
		(ce && tick && ctrl.jumpEn && jumpCond) |=> (addr_reg[0] == $past(ctrl.jumpAddr));
	endproperty
	a_jump: assert property (p_jump) else $error("jump not taken");

	// Sixteen shifts per vector leave the shifter empty once the count saturates
	property p_serial_frame;
		@(posedge clk) disable iff (!nrst)
		(ce && serCnt_reg == `TPG_SER_LAST && !tick_d) |=> (shift_reg[1] == `TPG_WORD_ZERO);
	endproperty
	a_serial_frame: assert property (p_serial_frame) else $error("serial frame overran");

	property p_start;
		@(posedge clk) disable iff (!nrst)
		(ce && state_reg == tpg_pkg::TPG_IDLE && ctrl.start) |=> running;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_analog;
		@(posedge clk) disable iff (!nrst)
		(ce && state_reg == tpg_pkg::TPG_PAUSED && !ctrl.pause) |=> analogTrigger;
	endproperty
	a_analog: assert property (p_analog) else $error("analog trigger missing");

	property p_step_done;
		@(posedge clk) disable iff (!nrst)
		(ce && state_reg == tpg_pkg::TPG_RUN && tick && ctrl.singleStep && !ctrl.stop
			&& !ctrl.pause) |=> (stepDone && !running);
	endproperty
	a_step_done: assert property (p_step_done) else $error("step end not reached");

	property p_cascade_step;
		@(posedge clk) disable iff (!nrst)
		(ce && state_reg == tpg_pkg::TPG_RUN && genCfg[1].cascade && adv[0] && wrap[0]
			&& !wrap[1]) |=> (addr_reg[1] == $past(addr_reg[1]) + AW'(1));
	endproperty
	a_cascade_step: assert property (p_cascade_step) else $error("cascade stalled");
endmodule // tpg_bank

// file: verilog/tpg_consts.svh
// Constants for the test pattern generator bank
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH
`define TPG_NUM_GEN      4
`define TPG_GEN_WIDTH    16
`define TPG_ADDR_WIDTH   10
`define TPG_NUM_CARDS    18
`define TPG_CLK_MHZ      200
`define TPG_VEC_MHZ      10
`define TPG_EDGE_NS      5
`define TPG_CLK_NS       5
`define TPG_NS_PER_US    1000
`define TPG_ADDR_ONE     10'h001
`define TPG_VEC_DIV      (`TPG_CLK_MHZ / `TPG_VEC_MHZ)
`define TPG_SER_CNT_W    4
`define TPG_SER_LAST     4'hF
`define TPG_DIV_W        5
`define TPG_ADDR_ZERO    10'h000
`define TPG_WORD_ZERO    16'h0000
`endif

// file: verilog/tpg_pkg.sv
// Types for the test pattern generator bank
package tpg_pkg;
	typedef enum logic [1:0]
	{
		TPG_IDLE   = 2'b00,
		TPG_RUN    = 2'b01,
		TPG_PAUSED = 2'b10,
		TPG_STEPEND = 2'b11
	} tpg_state_type;

	typedef struct packed
	{
		logic        we;
		logic [1:0]  gen;
		logic [9:0]  addr;
		logic [15:0] data;
	} tpg_load_type;

	typedef struct packed
	{
		logic [9:0] startAddr;
		logic [9:0] length;
		logic       cascade;
		logic       serial;
	} tpg_gen_cfg_type;

	typedef struct packed
	{
		logic       start;
		logic       stop;
		logic       pause;
		logic       singleStep;
		logic       stepGo;
		logic       jumpEn;
		logic [9:0] jumpAddr;
	} tpg_ctrl_type;
endpackage

// file: verilog/tpg_pattern_ram.sv
// Pattern RAM with registered read data
`timescale 1ns/1ps
module tpg_pattern_ram
#(
	parameter int AW = 10,
	parameter int DW = 16
)
(
	input  wire logic          clk,
	input  wire logic          ce,
	input  wire logic          we,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [DW-1:0] wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [DW-1:0] rdData
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (ce && we)
			mem[wrAddr] <= wrData;
	end

	always_ff @(posedge clk)
	begin
		if (ce)
			rdData <= mem[rdAddr];
	end
endmodule // tpg_pattern_ram

// file: verif/tpg_card_model.sv
// Pin channel card model that captures backplane pattern data
`timescale 1ns/1ps
module tpg_card_model
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [63:0] patternWord,
	input  wire logic        vectorStrobe,
	input  wire logic        serialIn,
	output logic      [63:0] cardWord_reg,
	output logic      [15:0] cardSer_reg
);
	logic [4:0] bitCnt_reg;

	// A strobe opens a frame; the next sixteen edges shift in one word
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cardWord_reg <= 64'h0000000000000000;
			cardSer_reg  <= 16'h0000;
			bitCnt_reg   <= 5'h00;
		end
		else if (vectorStrobe)
		begin
			cardWord_reg <= patternWord;
			bitCnt_reg   <= 5'h10;
		end
		else if (bitCnt_reg != 5'h00)
		begin
			cardSer_reg <= {cardSer_reg[14:0], serialIn};
			bitCnt_reg  <= bitCnt_reg - 5'h01;
		end
	end
endmodule // tpg_card_model

// file: verif/tb_tpg_bank.sv
// Self-checking bench for the pattern generator bank
`timescale 1ns/1ps
module tb_tpg_bank;
	logic                           clk = 1'b0;
	logic                           nrst = 1'b0;
	logic                           ce = 1'b1;
	tpg_pkg::tpg_load_type          load = '0;
	tpg_pkg::tpg_gen_cfg_type [3:0] genCfg = '0;
	tpg_pkg::tpg_ctrl_type          ctrl = '0;
	logic                           jumpCond = 1'b0;
	logic [63:0]                    patternWord;
	logic [63:0]                    cardWord;
	logic [15:0]                    cardSer;
	logic [3:0]                     serialLine;
	logic                           vectorStrobe;
	logic                           sigStrobe;
	logic                           analogTrigger;
	logic                           running;
	logic                           stepDone;
	logic [15:0]                    mem [4][16];
	int                             err_total = 0;
	int                             n_tests = 0;
	always #50 clk = ~clk;
	tpg_bank dut (.clk(clk), .nrst(nrst), .ce(ce), .load(load), .genCfg(genCfg),
		.ctrl(ctrl), .jumpCond(jumpCond), .patternWord(patternWord),
		.serialLine(serialLine), .vectorStrobe(vectorStrobe), .sigStrobe(sigStrobe),
		.analogTrigger(analogTrigger), .running(running), .stepDone(stepDone));
	tpg_card_model card (.clk(clk), .nrst(nrst), .patternWord(patternWord),
		.vectorStrobe(vectorStrobe), .serialIn(serialLine[1]),
		.cardWord_reg(cardWord), .cardSer_reg(cardSer));
	task automatic chk(input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (e !== g)
		begin
			err_total++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("counts: compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Returns cycles waited; 100 means the event never came
	task automatic wait_on(input int s, output int n);
		bit hit;
		hit = 0;
		for (n = 0; n < 100 && !hit; n++)
		begin
			@(posedge clk);
			#1;
			hit = (s == 0) ? (vectorStrobe === 1'b1) :
				(s == 1) ? (analogTrigger === 1'b1) : (stepDone === 1'b1);
		end
		if (!hit)
			n = 100;
	endtask
	function automatic logic [15:0] exp_slice(input int g, input int k);
		int idx;
		idx = genCfg[g].cascade ? k / int'(genCfg[0].length) : k;
		return mem[g][int'(genCfg[g].startAddr) + idx % int'(genCfg[g].length)];
	endfunction
	function automatic logic [63:0] exp_word(input int k);
		logic [63:0] w;
		w = 64'h0000000000000000;
		for (int g = 0; g < 4; g++)
			if (!genCfg[g].serial)
				w[g*16 +: 16] = exp_slice(g, k);
		return w;
	endfunction
	function automatic logic [63:0] exp_ser(input int k);
		return genCfg[1].serial ? {48'h0, exp_slice(1, k)} : 64'h0;
	endfunction
	// Generator 0 address after a tick, with or without the jump
	function automatic int next_a(input int a, input bit c);
		if (c)
			return int'(ctrl.jumpAddr);
		if (a == int'(genCfg[0].startAddr) + int'(genCfg[0].length) - 1)
			return int'(genCfg[0].startAddr);
		return a + 1;
	endfunction
	task automatic go();
		@(negedge clk) ctrl.start = 1'b1;
		@(negedge clk) ctrl.start = 1'b0;
		@(negedge clk) chk(64'h1, {63'h0, running});
	endtask
	task automatic halt();
		@(negedge clk) ctrl.stop = 1'b1;
		@(negedge clk) ctrl.stop = 1'b0;
		repeat (2) @(negedge clk);
		chk(64'h0, {63'h0, running});
	endtask
	task automatic vectors(input int nv);
		int n;
		for (int k = 0; k < nv; k++)
		begin
			wait_on(0, n);
			if (k > 0)
			begin
				chk(64'd20, 64'(n));
				chk(exp_ser(k - 1), {48'h0, cardSer});
			end
			chk(exp_word(k), patternWord);
			chk(64'h1, {63'h0, sigStrobe});
		end
		@(posedge clk);
		@(negedge clk) chk(exp_word(nv - 1), cardWord);
	endtask
	initial
	begin
		int n;
		int ja;
		int a;
		logic [63:0] w;
		void'($urandom(28770));
		repeat (2) @(negedge clk);
		chk(64'h0, patternWord);
		nrst = 1'b1;
		for (int g = 0; g < 4; g++)
			for (int a = 0; a < 16; a++)
			begin
				mem[g][a] = (a == 2) ? 16'hFFFF : 16'($urandom);
				@(negedge clk) load = {1'b1, 2'(g), 10'(a), mem[g][a]};
			end
		@(negedge clk) load.we = 1'b0;
		genCfg[0] = {10'h002, 10'h003, 1'b0, 1'b0};
		genCfg[1] = {10'h007, 10'h001, 1'b0, 1'b0};
		genCfg[2] = {10'h000, 10'h004, 1'b0, 1'b0};
		genCfg[3] = {10'h009, 10'h002, 1'b0, 1'b0};
		go();
		vectors(8);
		halt();
		$display("test parallel done");
		genCfg[0].serial = 1'b1;
		genCfg[1].serial = 1'b1;
		genCfg[3].serial = 1'b1;
		go();
		vectors(4);
		halt();
		$display("test serial done");
		genCfg[1] = {10'h007, 10'h004, 1'b1, 1'b0};
		genCfg[3].serial = 1'b0;
		genCfg[0].serial = 1'b0;
		go();
		vectors(10);
		halt();
		$display("test cascade done");
		genCfg[1].cascade = 1'b0;
		ja = 2 + int'($urandom % 3);
		ctrl.jumpAddr = 10'(ja);
		ctrl.jumpEn = 1'b1;
		jumpCond = 1'b1;
		a = int'(genCfg[0].startAddr);
		go();
		for (int k = 0; k < 8; k++)
		begin
			wait_on(0, n);
			w = exp_word(k);
			w[15:0] = mem[0][a];
			chk(w, patternWord);
			a = next_a(a, jumpCond);
			@(negedge clk) jumpCond = 1'($urandom);
		end
		ctrl.jumpEn = 1'b0;
		jumpCond = 1'b0;
		halt();
		$display("test jump done");
		go();
		@(negedge clk) ctrl.pause = 1'b1;
		wait_on(0, n);
		chk(64'd100, 64'(n));
		@(negedge clk) ctrl.pause = 1'b0;
		wait_on(1, n);
		chk(64'h1, {63'h0, n < 100});
		halt();
		$display("test pause done");
		ctrl.singleStep = 1'b1;
		go();
		wait_on(2, n);
		chk(64'h1, {63'h0, n < 100});
		repeat (4) @(negedge clk);
		chk(64'h1, {63'h0, stepDone});
		chk(64'h0, {63'h0, running});
		@(negedge clk) ctrl.stepGo = 1'b1;
		@(negedge clk) ctrl.stepGo = 1'b0;
		wait_on(0, n);
		chk(64'h1, {63'h0, n < 100});
		halt();
		ctrl.singleStep = 1'b0;
		$display("test single step done");
		go();
		@(negedge clk) ce = 1'b0;
		wait_on(0, n);
		chk(64'd100, 64'(n));
		@(negedge clk) ce = 1'b1;
		halt();
		$display("test clock enable done");
		wrap_up();
	end
	initial
	begin
		#500000;
		err_total++;
		wrap_up();
	end
endmodule // tb_tpg_bank
